// *** aar_avg.v ***
// result averager: sums a set number of conversions and returns the mean
// assumes samples arrive as one-cycle strobes on mclk_i from the converter
`include "aar_defs.vh"
`timescale 1ns/100ps
module aar_avg #(
   parameter DATA_W = 10,
   parameter ACC_W = 15
) (
   input wire mclk_i, // block clock
   input wire reset_n_i, // async reset, active low
   input wire clear_i, // drop a partial sum
   input wire [5:0] conv_count_i, // conversions per result
   input wire [2:0] shift_i, // log2 of conv_count_i
   input wire sample_valid_i, // one conversion done
   input wire [DATA_W-1:0] sample_i, // conversion value
   output reg result_valid_o, // one-cycle result strobe
   output reg [DATA_W-1:0] result_o // averaged result
);

   reg [ACC_W-1:0] acc_q;
   reg [5:0] cnt_q;
   wire [ACC_W-1:0] sum_w;
   wire [ACC_W-1:0] mean_w;
   wire [5:0] cnt_inc_w;

   // accumulator wide enough for 32 full-scale samples, so no overflow
   assign sum_w = acc_q + {{(ACC_W-DATA_W){1'b0}}, sample_i};
   assign mean_w = sum_w >> shift_i;
   assign cnt_inc_w = cnt_q + 6'h01;

   // =====================================================================
   // sum, then divide by shifting; the mean truncates toward zero
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_q <= {ACC_W{1'b0}};
         cnt_q <= 6'h00;
         result_valid_o <= 1'b0;
         result_o <= {DATA_W{1'b0}};
      end else begin
         result_valid_o <= 1'b0;
         if (clear_i) begin
            acc_q <= {ACC_W{1'b0}};
            cnt_q <= 6'h00;
         end else if (sample_valid_i) begin
            if (cnt_inc_w >= conv_count_i) begin
               result_o <= mean_w[DATA_W-1:0];
               result_valid_o <= 1'b1;
               acc_q <= {ACC_W{1'b0}};
               cnt_q <= 6'h00;
            end else begin
               acc_q <= sum_w;
               cnt_q <= cnt_inc_w;
            end
         end
      end
   end

endmodule

// *** aar_defs.vh ***
// constants for the averaging and reset command decode of the serial adc
// assumes inclusion by bare name from the averager and top design files of the block; the synchroniser does not include it
`ifndef AAR_DEFS_VH
`define AAR_DEFS_VH

// =====================================================================
// command byte selection
`define AAR_AVG_SEL_MASK 8'he0
`define AAR_AVG_SEL_CODE 8'h20
`define AAR_RST_SEL_MASK 8'hf0
`define AAR_RST_SEL_CODE 8'h10

// =====================================================================
// averaging register fields
`define AAR_AVG_EN_BIT 4
`define AAR_AVG_CNT_HI 3
`define AAR_AVG_CNT_LO 2
`define AAR_REP_CNT_HI 1
`define AAR_REP_CNT_LO 0
`define AAR_AVG_EN_RST 1'h0
`define AAR_AVG_CNT_RST 2'h0
`define AAR_REP_CNT_RST 2'h0

// =====================================================================
// reset register field
`define AAR_RST_FIFO_BIT 3

// =====================================================================
// mode codes from the setup and conversion registers
`define AAR_CLK_MODE_EXT 2'h3
`define AAR_SCAN_REPEAT 2'h2

// =====================================================================
// field encodings
`define AAR_CODE_0 2'h0
`define AAR_CODE_1 2'h1
`define AAR_CODE_2 2'h2
`define AAR_CONV_1 6'h01
`define AAR_CONV_4 6'h04
`define AAR_CONV_8 6'h08
`define AAR_CONV_16 6'h10
`define AAR_CONV_32 6'h20
`define AAR_SHIFT_1 3'h0
`define AAR_SHIFT_4 3'h2
`define AAR_SHIFT_8 3'h3
`define AAR_SHIFT_16 3'h4
`define AAR_SHIFT_32 3'h5
`define AAR_REP_4 5'h04
`define AAR_REP_8 5'h08
`define AAR_REP_12 5'h0c
`define AAR_REP_16 5'h10

// =====================================================================
// timing
`define AAR_MCLK_KHZ 20000
`define AAR_SCLK_MAX_KHZ 4800
`define AAR_PACE_MIN_CYC ((`AAR_MCLK_KHZ + `AAR_SCLK_MAX_KHZ - 1) / `AAR_SCLK_MAX_KHZ)
`define AAR_BIT_LAST 3'h7

`endif

// *** aar_host.sv ***
// serial host model: frames command bytes msb first on its own clock
// assumes mclk_i is the block clock; sclk idles low between frames
`timescale 1ns/100ps
module aar_host (
   input wire logic mclk_i, // pacing clock
   output logic sclk_o = 1'b0, // serial clock, still outside frames
   output logic cs_n_o = 1'b1, // chip select, active low
   output logic din_o = 1'b0 // serial data
);
   // n bits of b, hp mclk cycles per half period; n below 8 is a torn byte
   task automatic xfer(input logic [7:0] b, input int n, input int hp);
      int i;
      @(posedge mclk_i);
      cs_n_o <= 1'b0;
      for (i = 7; i > 7 - n; i--) begin
         din_o <= b[i];
         repeat (hp) @(posedge mclk_i);
         sclk_o <= 1'b1;
         repeat (hp) @(posedge mclk_i);
         sclk_o <= 1'b0;
      end
      repeat (hp) @(posedge mclk_i);
      cs_n_o <= 1'b1;
      din_o <= ~din_o; // released line must not keep the last bit
   endtask
endmodule

// *** aar_sync.v ***
// two flip-flop synchroniser for pins arriving from the serial host
// assumes the pins are quasi-static relative to mclk_i, no bus coherency
`timescale 1ns/100ps
module aar_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input wire mclk_i, // block clock
   input wire reset_n_i, // async reset, active low
   input wire [WIDTH-1:0] async_i, // pins from outside the domain
   output reg [WIDTH-1:0] sync_o // synchronised copy
);

   reg [WIDTH-1:0] meta_q;

   // =====================================================================
   // first stage feeds only the second stage
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule

// *** aar_top.v ***
// averaging and reset register command decode for a four-channel serial adc
// assumes: serial pins come from the host asynchronously to mclk_i; the clock
// and scan mode codes and the conversion strobes come from logic on mclk_i
`include "aar_defs.vh"
`timescale 1ns/100ps
module aar_top #(
   parameter DATA_W = 10
) (
   input wire mclk_i, // 20 MHz block clock
   input wire reset_n_i, // async reset, active low
   input wire sclk_i, // serial clock from host
   input wire cs_n_i, // chip select, active low
   input wire din_i, // serial data in
   input wire [1:0] clock_mode_i, // clock mode code from setup logic
   input wire [1:0] scan_mode_i, // scan mode code from conversion logic
   input wire sample_valid_i, // one conversion finished
   input wire [DATA_W-1:0] sample_i, // raw conversion value
   output reg byte_valid_o, // pulse: a full byte was taken
   output reg [7:0] byte_o, // last full byte taken
   output reg average_enable_o, // stored averaging enable bit
   output reg average_active_o, // averaging really in use
   output reg [5:0] conv_per_result_o, // conversions per result
   output reg [4:0] repeat_results_o, // results per repeated scan
   output reg repeat_active_o, // repeated single-channel scan selected
   output reg fifo_clear_o, // pulse: empty the result fifo
   output reg regs_reset_o, // pulse: all registers to power-up
   output reg ext_pace_o, // pulse: externally timed conversion
   output reg pace_overrun_o, // sticky: serial clock above limit
   output wire result_valid_o, // pulse: averaged result ready
   output wire [DATA_W-1:0] result_o // averaged result
);

   // shortest legal gap between serial rising edges in external mode, in mclk cycles;
   // the integer keeps the rounding and the part-select makes the cut to 8 bits plain
   localparam integer PACE_MIN_I = `AAR_PACE_MIN_CYC;
   localparam [7:0] PACE_MIN = PACE_MIN_I[7:0];

   // =====================================================================
   // decode helpers for the effective averaging decode; the count feeds the outputs and the averager, the shift the averager only

   // conversions per result for an enable bit and count code
   function [5:0] aar_conv_count;
      input en;
      input [1:0] code;
      begin
         if (!en) begin
            aar_conv_count = `AAR_CONV_1;
         end else begin
            case (code)
               `AAR_CODE_0: aar_conv_count = `AAR_CONV_4;
               `AAR_CODE_1: aar_conv_count = `AAR_CONV_8;
               `AAR_CODE_2: aar_conv_count = `AAR_CONV_16;
               default: aar_conv_count = `AAR_CONV_32;
            endcase
         end
      end
   endfunction

   // divide-by-shift that goes with aar_conv_count
   function [2:0] aar_conv_shift;
      input en;
      input [1:0] code;
      begin
         if (!en) begin
            aar_conv_shift = `AAR_SHIFT_1;
         end else begin
            case (code)
               `AAR_CODE_0: aar_conv_shift = `AAR_SHIFT_4;
               `AAR_CODE_1: aar_conv_shift = `AAR_SHIFT_8;
               `AAR_CODE_2: aar_conv_shift = `AAR_SHIFT_16;
               default: aar_conv_shift = `AAR_SHIFT_32;
            endcase
         end
      end
   endfunction

   // =====================================================================
   // pin synchronisers

   wire [2:0] pins_s;
   wire sclk_s;
   wire cs_n_s;
   wire din_s;

   // all three pins pass the same two stages, so a data bit keeps its place
   // against its clock edge; the host must change data away from that edge
   // chip select idles high so the link starts deselected
   aar_sync #(
      .WIDTH(3),
      .RESET_VAL(3'h2)
   ) u_sync (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .async_i({sclk_i, cs_n_i, din_i}),
      .sync_o(pins_s)
   );

   assign sclk_s = pins_s[2];
   assign cs_n_s = pins_s[1];
   assign din_s = pins_s[0];

   // =====================================================================
   // serial byte capture

   reg sclk_prev_q;
   reg [6:0] shift_q;
   reg [2:0] bit_q;
   reg [7:0] cmd_q;
   reg cmd_stb_q;
   wire sclk_rise;
   wire [7:0] cmd_w;

   // the edge detector resets to the idle low level of the serial clock, so
   // no false edge follows reset
   assign sclk_rise = sclk_s & ~sclk_prev_q;
   assign cmd_w = {shift_q, din_s};

   // a deselect mid-byte resets the bit count, so partial bytes never land
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sclk_prev_q <= 1'b0;
         shift_q <= 7'h00;
         bit_q <= 3'h0;
         cmd_q <= 8'h00;
         cmd_stb_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
         cmd_stb_q <= 1'b0;
         if (cs_n_s) begin
            bit_q <= 3'h0;
         end else if (sclk_rise) begin
            shift_q <= cmd_w[6:0];
            bit_q <= bit_q + 3'h1;
            if (bit_q == `AAR_BIT_LAST) begin
               cmd_q <= cmd_w;
               cmd_stb_q <= 1'b1;
            end
         end
      end
   end

   // =====================================================================
   // command decode

   wire avg_write;
   wire rst_write;
   wire rst_fifo_only;

   // both decodes look at the held byte only during its one-cycle strobe; other
   // prefixes (conversion, setup) give only the byte strobe here
   assign avg_write = cmd_stb_q & ((cmd_q & `AAR_AVG_SEL_MASK) == `AAR_AVG_SEL_CODE);
   assign rst_write = cmd_stb_q & ((cmd_q & `AAR_RST_SEL_MASK) == `AAR_RST_SEL_CODE);
   assign rst_fifo_only = cmd_q[`AAR_RST_FIFO_BIT];

   // =====================================================================
   // averaging configuration register

   reg avg_en_q;
   reg [1:0] avg_cnt_q;
   reg [1:0] rep_cnt_q;

   // a fifo-only reset leaves these alone; a full reset restores defaults
   // the two branches never meet, since both decode the one held byte
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         avg_en_q <= `AAR_AVG_EN_RST;
         avg_cnt_q <= `AAR_AVG_CNT_RST;
         rep_cnt_q <= `AAR_REP_CNT_RST;
      end else if (avg_write) begin
         avg_en_q <= cmd_q[`AAR_AVG_EN_BIT];
         avg_cnt_q <= cmd_q[`AAR_AVG_CNT_HI:`AAR_AVG_CNT_LO];
         rep_cnt_q <= cmd_q[`AAR_REP_CNT_HI:`AAR_REP_CNT_LO];
      end else if (rst_write && !rst_fifo_only) begin
         avg_en_q <= `AAR_AVG_EN_RST;
         avg_cnt_q <= `AAR_AVG_CNT_RST;
         rep_cnt_q <= `AAR_REP_CNT_RST;
      end
   end

   // =====================================================================
   // effective averaging, independent of scan mode

   wire ext_clk_mode;
   wire avg_eff;
   wire [5:0] conv_count_w;
   wire [2:0] conv_shift_w;
   reg [4:0] rep_results_w;

   assign ext_clk_mode = (clock_mode_i == `AAR_CLK_MODE_EXT);
   // limitation: a clock mode change acts at once, even inside an averaged
   // result; the averager keeps its partial sum across it
   // scan mode is not looked at: every scan mode may average
   assign avg_eff = avg_en_q & ~ext_clk_mode;
   assign conv_count_w = aar_conv_count(avg_eff, avg_cnt_q);
   assign conv_shift_w = aar_conv_shift(avg_eff, avg_cnt_q);

   // repeat count decode for the repeated single-channel scan
   always @* begin
      case (rep_cnt_q)
         `AAR_CODE_0: rep_results_w = `AAR_REP_4;
         `AAR_CODE_1: rep_results_w = `AAR_REP_8;
         `AAR_CODE_2: rep_results_w = `AAR_REP_12;
         default: rep_results_w = `AAR_REP_16;
      endcase
   end

   // =====================================================================
   // external pacing from the serial clock

   reg [7:0] gap_q;
   wire gap_short;

   // gap counts mclk cycles between serial rising edges, saturating
   // saturation keeps a long idle gap from wrapping into a false overrun
   assign gap_short = sclk_rise & (gap_q < PACE_MIN) & ext_clk_mode;

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gap_q <= 8'hff;
      end else if (sclk_rise) begin
         gap_q <= 8'h01;
      end else if (gap_q != 8'hff) begin
         gap_q <= gap_q + 8'h01;
      end
   end

   // =====================================================================
   // registered outputs; settings follow the registers one cycle later
   // so the config outputs trail byte_valid_o by one cycle

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         byte_valid_o <= 1'b0;
         byte_o <= 8'h00;
         average_enable_o <= `AAR_AVG_EN_RST;
         average_active_o <= 1'b0;
         conv_per_result_o <= `AAR_CONV_1;
         repeat_results_o <= `AAR_REP_4;
         repeat_active_o <= 1'b0;
         fifo_clear_o <= 1'b0;
         regs_reset_o <= 1'b0;
         ext_pace_o <= 1'b0;
         pace_overrun_o <= 1'b0;
      end else begin
         byte_valid_o <= cmd_stb_q;
         if (cmd_stb_q) begin
            byte_o <= cmd_q;
         end
         average_enable_o <= avg_en_q;
         average_active_o <= avg_eff;
         conv_per_result_o <= conv_count_w;
         repeat_results_o <= rep_results_w;
         repeat_active_o <= (scan_mode_i == `AAR_SCAN_REPEAT);
         // a full reset also empties the fifo, as at power-up
         fifo_clear_o <= rst_write;
         regs_reset_o <= rst_write & ~rst_fifo_only;
         ext_pace_o <= sclk_rise & ~cs_n_s & ext_clk_mode;
         // a too-fast edge in the same cycle as a full reset still sets the flag
         if (gap_short) begin
            pace_overrun_o <= 1'b1;
         end else if (rst_write && !rst_fifo_only) begin
            pace_overrun_o <= 1'b0;
         end
      end
   end

   // =====================================================================
   // result averaging; an averaging register write or any reset drops a partial sum,
   // trading one lost partial result for never mixing two written counts

   wire avg_clear;

   assign avg_clear = avg_write | rst_write;

   aar_avg #(
      .DATA_W(DATA_W),
      .ACC_W(DATA_W + 5)
   ) u_avg (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .clear_i(avg_clear),
      .conv_count_i(conv_count_w),
      .shift_i(conv_shift_w),
      .sample_valid_i(sample_valid_i),
      .sample_i(sample_i),
      .result_valid_o(result_valid_o),
      .result_o(result_o)
   );

endmodule

// *** aar_top_props.sv ***
// checker for the averaging and reset command decode of the serial adc
// assumes it sees only the aar_top ports and is bound in at the foot
`timescale 1ns/100ps
module aar_top_props #(
   parameter DATA_W = 10
) (
   input wire logic mclk_i, // block clock
   input wire logic reset_n_i, // async reset, active low
   input wire logic sclk_i, // serial clock
   input wire logic cs_n_i, // chip select
   input wire logic din_i, // serial data
   input wire logic [1:0] clock_mode_i, // clock mode code
   input wire logic [1:0] scan_mode_i, // scan mode code
   input wire logic sample_valid_i, // conversion strobe
   input wire logic [DATA_W-1:0] sample_i, // conversion value
   input wire logic byte_valid_o, // byte strobe
   input wire logic [7:0] byte_o, // last byte
   input wire logic average_enable_o, // stored enable
   input wire logic average_active_o, // averaging in use
   input wire logic [5:0] conv_per_result_o, // conversions per result
   input wire logic [4:0] repeat_results_o, // results per scan
   input wire logic repeat_active_o, // repeat scan selected
   input wire logic fifo_clear_o, // fifo clear strobe
   input wire logic regs_reset_o, // full reset strobe
   input wire logic ext_pace_o, // paced conversion strobe
   input wire logic pace_overrun_o, // pacing too fast
   input wire logic result_valid_o, // result strobe
   input wire logic [DATA_W-1:0] result_o // averaged result
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // =====================================================================
   // averaging settings
   property p_inact_one;
      !average_active_o |-> conv_per_result_o == 6'h01;
   endproperty
   a_inact_one: assert property (p_inact_one) else $error("count not one");
   property p_act_set;
      average_active_o |-> average_enable_o && conv_per_result_o inside {6'h04, 6'h08, 6'h10, 6'h20};
   endproperty
   a_act_set: assert property (p_act_set) else $error("bad active count");
   property p_ext_off;
      clock_mode_i == 2'h3 |=> !average_active_o;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("averaging in ext mode");
   property p_rep_mode;
      1'b1 |=> repeat_active_o == ($past(scan_mode_i) == 2'h2);
   endproperty
   a_rep_mode: assert property (p_rep_mode) else $error("repeat flag wrong");
   // config outputs land one cycle after the byte strobe; byte_o still holds then
   property p_avg_wr;
      byte_valid_o && byte_o[7:5] == 3'h1 |=> average_enable_o == byte_o[4]
         && repeat_results_o == {1'b0, byte_o[1:0], 2'h0} + 5'h04
         && (!average_active_o || conv_per_result_o == (6'h04 << byte_o[3:2]));
   endproperty
   a_avg_wr: assert property (p_avg_wr) else $error("avg write fields wrong");
   // =====================================================================
   // reset register and framing
   property p_fifo_only;
      fifo_clear_o && !regs_reset_o |-> byte_valid_o && byte_o[7:3] == 5'h03
         ##1 $stable(average_enable_o) && $stable(repeat_results_o);
   endproperty
   a_fifo_only: assert property (p_fifo_only) else $error("fifo clear wrong");
   property p_full;
      regs_reset_o |-> fifo_clear_o && byte_o[7:3] == 5'h02
         ##1 !average_enable_o && repeat_results_o == 5'h04 && conv_per_result_o == 6'h01;
   endproperty
   a_full: assert property (p_full) else $error("full reset wrong");
   property p_bv_pulse;
      byte_valid_o |=> !byte_valid_o [*4];
   endproperty
   a_bv_pulse: assert property (p_bv_pulse) else $error("byte strobe too close");
   property p_pace;
      ext_pace_o |-> $past(clock_mode_i) == 2'h3;
   endproperty
   a_pace: assert property (p_pace) else $error("pace outside ext mode");
   c_avg: cover property (byte_valid_o && byte_o[7:5] == 3'h1);
   c_fifo: cover property (fifo_clear_o && !regs_reset_o);
   c_full: cover property (regs_reset_o);
   c_pace: cover property (ext_pace_o);
endmodule

bind aar_top aar_top_props #(.DATA_W(DATA_W)) u_props (.mclk_i, .reset_n_i, .sclk_i, .cs_n_i,
   .din_i, .clock_mode_i, .scan_mode_i, .sample_valid_i, .sample_i, .byte_valid_o, .byte_o,
   .average_enable_o, .average_active_o, .conv_per_result_o, .repeat_results_o,
   .repeat_active_o, .fifo_clear_o, .regs_reset_o, .ext_pace_o, .pace_overrun_o,
   .result_valid_o, .result_o);

// *** adc_averaging_reset_regs_bench.sv ***
// self-checking bench for aar_top driven by the serial host model
// assumes the checker is bound in and the host model compiles first
`timescale 1ns/100ps
module adc_averaging_reset_regs_bench;
   logic mclk_i = 1'b0, reset_n_i = 1'b0, sample_valid_i = 1'b0;
   logic [1:0] clock_mode_i = 2'h0, scan_mode_i = 2'h0;
   logic [9:0] sample_i = 10'h000, last_res = 10'h000;
   wire sclk, cs_n, din, bv, en, act, rep_act, fc, rr, ep, ovr, rv;
   wire [7:0] byte_o;
   wire [5:0] conv;
   wire [4:0] reps;
   wire [9:0] res;
   int err_count = 0, checked = 0, n_bv, n_fc, n_rr, n_ep, n_rv, c;
   aar_host u_host (.mclk_i(mclk_i), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
   aar_top #(.DATA_W(10)) u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
      .cs_n_i(cs_n), .din_i(din), .clock_mode_i(clock_mode_i), .scan_mode_i(scan_mode_i),
      .sample_valid_i(sample_valid_i), .sample_i(sample_i), .byte_valid_o(bv),
      .byte_o(byte_o), .average_enable_o(en), .average_active_o(act),
      .conv_per_result_o(conv), .repeat_results_o(reps), .repeat_active_o(rep_act),
      .fifo_clear_o(fc), .regs_reset_o(rr), .ext_pace_o(ep), .pace_overrun_o(ovr),
      .result_valid_o(rv), .result_o(res));
   initial forever #25 mclk_i = ~mclk_i;
   // =====================================================================
   // strobe counters: pulses last one cycle, so they are tallied here
   always @(posedge mclk_i) begin
      n_bv += (bv === 1'b1);
      n_fc += (fc === 1'b1);
      n_rr += (rr === 1'b1);
      n_ep += (ep === 1'b1);
      n_rv += (rv === 1'b1);
      if (rv === 1'b1) last_res = res;
   end
   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask
   // one whole byte, then time for the registered outputs to settle
   task automatic wr(input logic [7:0] b);
      n_bv = 0;
      n_fc = 0;
      n_rr = 0;
      n_ep = 0;
      u_host.xfer(b, 8, 4);
      repeat (4) @(posedge mclk_i);
   endtask
   task automatic samp(input logic [9:0] v);
      sample_valid_i <= 1'b1;
      sample_i <= v;
      @(posedge mclk_i);
      sample_valid_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (10000) @(posedge mclk_i);
      err_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      wrap_up();
   end
   // =====================================================================
   // test sequence
   initial begin
      repeat (5) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      chk(conv, 1, "reset conv");
      chk(reps, 4, "reset reps");
      for (c = 0; c < 4; c++) begin
         scan_mode_i <= c[1:0];
         wr(8'(8'h30 | (c << 2) | c));
         chk({en, act}, 2'h3, "enable");
         chk(conv, 4 << c, "avg count");
         chk(reps, 4 * (c + 1), "repeat count");
         chk(rep_act, c == 2, "repeat mode");
      end
      $display("test codes done");
      clock_mode_i <= 2'h3;
      wr(8'h40);
      chk({act, conv, ovr}, 8'h02, "ext mode");
      chk(n_ep, 8, "pace count");
      chk({n_bv, byte_o, en}, {32'd1, 8'h40, 1'b1}, "other byte");
      clock_mode_i <= 2'h0;
      wr(8'h2d);
      chk({en, conv, reps}, {1'b0, 6'h01, 5'h08}, "avg off");
      $display("test modes done");
      n_bv = 0;
      u_host.xfer(8'h3f, 5, 4);
      chk({n_bv, en}, 33'h0, "torn byte");
      wr(8'h36);
      chk({en, conv, reps}, {1'b1, 6'h08, 5'h0c}, "after torn");
      $display("test framing done");
      wr(8'h32);
      n_rv = 0;
      samp(10'h001);
      samp(10'h002);
      samp(10'h003);
      samp(10'h005);
      repeat (3) @(posedge mclk_i);
      chk({n_rv, last_res}, {32'd1, 10'h002}, "mean of four");
      samp(10'h3ff);
      samp(10'h3ff);
      wr(8'h1f);
      chk({n_fc, n_rr, en, reps}, {32'd1, 32'd0, 1'b1, 5'h0c}, "fifo clear");
      n_rv = 0;
      samp(10'h004);
      samp(10'h004);
      samp(10'h004);
      samp(10'h008);
      repeat (3) @(posedge mclk_i);
      chk({n_rv, last_res}, {32'd1, 10'h005}, "partial dropped");
      wr(8'h20);
      n_rv = 0;
      samp(10'h2a5);
      repeat (3) @(posedge mclk_i);
      chk({n_rv, last_res}, {32'd1, 10'h2a5}, "single pass");
      $display("test averaging done");
      wr(8'h36);
      wr(8'h08);
      chk({n_fc, n_bv}, {32'd0, 32'd1}, "not reset reg");
      // a deliberately too fast serial clock in external mode must raise the flag
      clock_mode_i <= 2'h3;
      u_host.xfer(8'h40, 8, 2);
      repeat (4) @(posedge mclk_i);
      chk(ovr, 1'b1, "pace overrun");
      clock_mode_i <= 2'h0;
      wr(8'h10);
      chk({n_fc, n_rr}, {32'd1, 32'd1}, "full reset");
      chk({en, conv, reps, ovr}, {1'b0, 6'h01, 5'h04, 1'b0}, "defaults");
      $display("test reset done");
      wrap_up();
   end
endmodule
